// ---- rpa_alternator.sv ----
// redundant pump alternator: package, scan timer and alternator top
//==============================================================================
// package
//==============================================================================
package rpa_pkg;
    localparam int unsigned PRESET_W       = 16;
    localparam int unsigned CLK_PERIOD_NS  = 40;
    localparam int unsigned TICK_NS        = 100_000_000;
    localparam int unsigned TICK_CYCLES_DEF = TICK_NS / CLK_PERIOD_NS;

    localparam logic [PRESET_W-1:0] LIFE_PRESET    = 16'h7530;
    localparam logic [PRESET_W-1:0] START_PULSE_PT = 16'h0014;
    localparam logic [PRESET_W-1:0] OFF_DELAY_PT   = 16'h0032;
    localparam logic [PRESET_W-1:0] LOW_PRESS_PT   = 16'h0064;

    typedef enum logic [1:0] {
        RPA_ALT_START,
        RPA_TIMED_SWITCH,
        RPA_SWITCH_ON_FAIL
    } rpa_variant_t;

    typedef enum logic [1:0] {
        RPA_ON_DELAY,
        RPA_PULSE,
        RPA_OFF_DELAY
    } rpa_timer_kind_t;

    typedef struct packed {
        logic stop_nc;
        logic start;
        logic aux1;
        logic aux2;
        logic low_press;
    } rpa_in_t;

    typedef struct packed {
        logic pump1;
        logic pump2;
        logic hour_timer_power;
        logic hour_timer_reset;
    } rpa_out_t;
endpackage : rpa_pkg

`timescale 1ns/100ps
`default_nettype none

//==============================================================================
// tick-based timer: on_delay_timer, pulse_timer or off_delay_timer
//==============================================================================
module rpa_timer #(
    parameter rpa_pkg::rpa_timer_kind_t KIND = rpa_pkg::RPA_ON_DELAY
) (
    input  wire logic                         clk_i,
    input  wire logic                         nrst_i,
    input  wire logic                         tick_i,
    input  wire logic                         in_i,
    input  wire logic [rpa_pkg::PRESET_W-1:0] preset_i,
    output logic                              q_o
);
    import rpa_pkg::*;

    logic [PRESET_W-1:0] cnt_ff;
    logic                active_ff;
    logic                in_prev_ff;
    logic                start;

    // output follows the current input so later rungs see it in the same scan
    assign start = in_i & ~in_prev_ff & ~active_ff;

    always_comb begin
        case (KIND)
            RPA_ON_DELAY:  q_o = in_i & (cnt_ff >= preset_i);
            RPA_PULSE:     q_o = active_ff | start;
            RPA_OFF_DELAY: q_o = in_i | active_ff;
            default:       q_o = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            in_prev_ff <= 1'b0;
        end else begin
            in_prev_ff <= in_i;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_ff    <= '0;
            active_ff <= 1'b0;
        end else begin
            case (KIND)
                RPA_ON_DELAY: begin
                    if (!in_i) begin
                        cnt_ff <= '0;
                    end else if (tick_i && cnt_ff < preset_i) begin
                        cnt_ff <= cnt_ff + 1'b1;
                    end
                end
                RPA_PULSE: begin
                    if (start) begin
                        active_ff <= 1'b1;
                        cnt_ff    <= '0;
                    end else if (active_ff && tick_i) begin
                        if (cnt_ff + 1'b1 >= preset_i) begin
                            active_ff <= 1'b0;
                        end
                        cnt_ff <= cnt_ff + 1'b1;
                    end
                end
                RPA_OFF_DELAY: begin
                    if (in_i) begin
                        active_ff <= 1'b1;
                        cnt_ff    <= '0;
                    end else if (active_ff && tick_i) begin
                        if (cnt_ff + 1'b1 >= preset_i) begin
                            active_ff <= 1'b0;
                        end
                        cnt_ff <= cnt_ff + 1'b1;
                    end
                end
                default: begin
                    cnt_ff    <= '0;
                    active_ff <= 1'b0;
                end
            endcase
        end
    end
endmodule : rpa_timer

//==============================================================================
// alternator top
//==============================================================================
// Behaviour
// [RL1] alternate start pulses when idle and start rises
// [RL2] pulse toggles the selector latch
// [RL3] pump1 runs with stop, start/aux1, selector low
// [RL4] pump2 runs with stop, start/aux2, selector high
// [RL5] each new demand starts the other pump
// [RL6] timed run latch: start sets, stop clears
// [RL7] life pulse from self-clearing 30000-tick on-delay
// [RL8] life pulse toggles timed selector latch
// [RL9] 20-tick start pulse also resets hour timer
// [RL10] hour timer powered by aux, not during reset
// [RL11] pump1 off-delayed 50 ticks in timed variant
// [RL12] pump2 off-delayed 50 ticks in timed variant
// [RL13] failure run latch: start when idle, stop/timeout
// [RL14] start pulse on low-pressure or run rise
// [RL15] 100-tick low-pressure on-delay forms the timeout
// [RL16] failure selector toggles on start pulse rise
// [RL17] failure pump1 with run, pulse/aux1, selector low
// [RL18] failure pump2 with run, pulse/aux2, selector high
// [RL19] low-pressure bit arrives true while pressure low
// [RL20] rungs evaluated in order, outputs last
// [RL21] timer ticks are tenths of a second
// [RL22] rise is true one cycle on false-to-true
// [RL23] state holds; early reads see previous value
module rpa_alternator #(
    parameter int unsigned TICK_CYCLES = rpa_pkg::TICK_CYCLES_DEF
) (
    input  wire logic                  clk_i,
    input  wire logic                  nrst_i,
    input  wire rpa_pkg::rpa_variant_t variant_i,
    input  wire rpa_pkg::rpa_in_t      in_i,
    output rpa_pkg::rpa_out_t          out_o
);
    import rpa_pkg::*;

    function automatic logic rise(input logic now, input logic prev);
        return now & ~prev; // [RL22]
    endfunction : rise

    logic [31:0] div_ff;
    logic        tick;
    logic        start_prev_ff, run_prev_ff, press_prev_ff, sp_prev_ff;
    logic        sel_ff, run_ff, life_ff, tmo_ff;
    rpa_out_t    out_ff;

    logic        alt, timed, fail;
    logic        alt_pulse, run_n, sel_n, life_n, sp_n, tmo_n, tof1_n, tof2_n;
    logic        life_in, sp_in, tmo_in, tof1_in, tof2_in;
    rpa_out_t    out_n;

    //==========================================================================
    // scan time base, one tick per tenth of a second
    //==========================================================================
    assign tick = (div_ff == TICK_CYCLES - 1); // [RL21]

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            div_ff <= '0;
        end else if (tick) begin
            div_ff <= '0;
        end else begin
            div_ff <= div_ff + 32'h1;
        end
    end

    assign alt   = (variant_i == RPA_ALT_START);
    assign timed = (variant_i == RPA_TIMED_SWITCH);
    assign fail  = (variant_i == RPA_SWITCH_ON_FAIL);

    //==========================================================================
    // intermediate rungs, in index order; each clock is one scan
    //==========================================================================
    always_comb begin
        alt_pulse = 1'b0;
        run_n     = run_ff;
        sel_n     = sel_ff;
        case (variant_i)
            RPA_ALT_START: begin
                alt_pulse = ~in_i.aux1 & ~in_i.aux2 & rise(in_i.start, start_prev_ff); // [RL1]
                if (alt_pulse) begin
                    sel_n = ~sel_ff; // [RL2] [RL5]
                end
                run_n = 1'b0;
            end
            RPA_TIMED_SWITCH: begin
                // reset dominant latch: open stop wins over a held start
                if (!in_i.stop_nc) begin
                    run_n = 1'b0; // [RL6]
                end else if (in_i.start) begin
                    run_n = 1'b1; // [RL6]
                end
                if (life_n) begin
                    sel_n = ~sel_ff; // [RL8]
                end
            end
            RPA_SWITCH_ON_FAIL: begin
                // timeout read here is last scan's value, rung is computed later
                if (!in_i.stop_nc || tmo_ff) begin
                    run_n = 1'b0; // [RL13] [RL23]
                end else if (!in_i.aux1 && !in_i.aux2 && in_i.start) begin
                    run_n = 1'b1; // [RL13]
                end
                if (rise(sp_n, sp_prev_ff)) begin
                    sel_n = ~sel_ff; // [RL16]
                end
            end
            default: begin
                run_n = 1'b0;
            end
        endcase
    end

    // life timer input clears itself through its own previous output
    assign life_in = timed & (in_i.aux1 | in_i.aux2) & ~life_ff; // [RL7]
    assign sp_in   = timed ? (rise(run_n, run_prev_ff) | life_n) // [RL9]
                   : fail & (rise(in_i.low_press, press_prev_ff) | rise(run_n, run_prev_ff)); // [RL14] [RL19]
    assign tmo_in  = fail & in_i.low_press & run_n; // [RL15]
    assign tof1_in = timed & run_n & ~sel_n & (sp_n | in_i.aux1); // [RL11]
    assign tof2_in = timed & run_n & sel_n & (sp_n | in_i.aux2); // [RL12]

    rpa_timer #(.KIND(RPA_ON_DELAY)) u_life (
        .clk_i    (clk_i),
        .nrst_i   (nrst_i),
        .tick_i   (tick),
        .in_i     (life_in),
        .preset_i (LIFE_PRESET),
        .q_o      (life_n)
    );

    rpa_timer #(.KIND(RPA_PULSE)) u_start_pulse (
        .clk_i    (clk_i),
        .nrst_i   (nrst_i),
        .tick_i   (tick),
        .in_i     (sp_in),
        .preset_i (START_PULSE_PT),
        .q_o      (sp_n)
    );

    rpa_timer #(.KIND(RPA_ON_DELAY)) u_low_press (
        .clk_i    (clk_i),
        .nrst_i   (nrst_i),
        .tick_i   (tick),
        .in_i     (tmo_in),
        .preset_i (LOW_PRESS_PT),
        .q_o      (tmo_n)
    );

    rpa_timer #(.KIND(RPA_OFF_DELAY)) u_off1 (
        .clk_i    (clk_i),
        .nrst_i   (nrst_i),
        .tick_i   (tick),
        .in_i     (tof1_in),
        .preset_i (OFF_DELAY_PT),
        .q_o      (tof1_n)
    );

    rpa_timer #(.KIND(RPA_OFF_DELAY)) u_off2 (
        .clk_i    (clk_i),
        .nrst_i   (nrst_i),
        .tick_i   (tick),
        .in_i     (tof2_in),
        .preset_i (OFF_DELAY_PT),
        .q_o      (tof2_n)
    );

    //==========================================================================
    // output rungs, evaluated after all intermediate rungs
    //==========================================================================
    always_comb begin
        out_n = '0; // [RL20]
        case (variant_i)
            RPA_ALT_START: begin
                // pump2 is computed later, so pump1 sees its previous value
                out_n.pump1 = in_i.stop_nc & (in_i.start | in_i.aux1) & ~sel_n & ~out_ff.pump2; // [RL3]
                out_n.pump2 = in_i.stop_nc & (in_i.start | in_i.aux2) & sel_n & ~out_n.pump1; // [RL4]
            end
            RPA_TIMED_SWITCH: begin
                out_n.hour_timer_reset = sp_n; // [RL9]
                out_n.hour_timer_power = (in_i.aux1 | in_i.aux2) & ~sp_n; // [RL10]
                out_n.pump1            = tof1_n; // [RL11]
                out_n.pump2            = tof2_n; // [RL12]
            end
            RPA_SWITCH_ON_FAIL: begin
                out_n.pump1 = run_n & (sp_n | in_i.aux1) & ~sel_n & ~out_ff.pump2; // [RL17]
                out_n.pump2 = run_n & (sp_n | in_i.aux2) & sel_n & ~out_n.pump1; // [RL18]
            end
            default: begin
                out_n = '0;
            end
        endcase
    end

    //==========================================================================
    // state held between scans
    //==========================================================================
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sel_ff <= 1'b0;
            run_ff <= 1'b0;
        end else begin
            sel_ff <= sel_n; // [RL23]
            run_ff <= run_n;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            life_ff <= 1'b0;
            tmo_ff  <= 1'b0;
        end else begin
            life_ff <= life_n;
            tmo_ff  <= tmo_n;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            start_prev_ff <= 1'b0;
            run_prev_ff   <= 1'b0;
            press_prev_ff <= 1'b0;
            sp_prev_ff    <= 1'b0;
        end else begin
            start_prev_ff <= in_i.start;
            run_prev_ff   <= run_n;
            press_prev_ff <= in_i.low_press;
            sp_prev_ff    <= sp_n;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            out_ff <= '0;
        end else begin
            out_ff <= out_n;
        end
    end

    assign out_o = out_ff;

    //==========================================================================
    // assertions
    //==========================================================================
    property p_alt_pulse_cause;
        @(posedge clk_i) disable iff (!nrst_i)
        (alt && alt_pulse) |-> (!in_i.aux1 && !in_i.aux2 && in_i.start && !start_prev_ff);
    endproperty
    a_alt_pulse_cause: assert property (p_alt_pulse_cause) else $error("alt pulse without its cause"); // [RL1]

    property p_alt_toggle;
        @(posedge clk_i) disable iff (!nrst_i)
        (alt && alt_pulse) |=> (sel_ff != $past(sel_ff));
    endproperty
    a_alt_toggle: assert property (p_alt_toggle) else $error("selector did not toggle on pulse"); // [RL2]

    property p_alt_pump1;
        @(posedge clk_i) disable iff (!nrst_i)
        ($past(alt) && out_ff.pump1) |-> ($past(in_i.stop_nc) && $past(in_i.start || in_i.aux1) && !sel_ff);
    endproperty
    a_alt_pump1: assert property (p_alt_pump1) else $error("pump1 driven without permission"); // [RL3]

    property p_alt_pump2;
        @(posedge clk_i) disable iff (!nrst_i)
        ($past(alt) && out_ff.pump2) |-> ($past(in_i.stop_nc) && $past(in_i.start || in_i.aux2) && sel_ff);
    endproperty
    a_alt_pump2: assert property (p_alt_pump2) else $error("pump2 driven without permission"); // [RL4]

    property p_excl;
        @(posedge clk_i) disable iff (!nrst_i)
        !timed |=> !(out_ff.pump1 && out_ff.pump2);
    endproperty
    a_excl: assert property (p_excl) else $error("both pump coils driven"); // [RL17]

    property p_stop_clears_run;
        @(posedge clk_i) disable iff (!nrst_i)
        ((timed || fail) && !in_i.stop_nc) |=> !run_ff;
    endproperty
    a_stop_clears_run: assert property (p_stop_clears_run) else $error("run latch held with stop open"); // [RL6]

    property p_life_one_scan;
        @(posedge clk_i) disable iff (!nrst_i)
        (timed && life_ff) |=> !life_ff;
    endproperty
    a_life_one_scan: assert property (p_life_one_scan) else $error("life pulse longer than one scan"); // [RL7]

    property p_timer_power;
        @(posedge clk_i) disable iff (!nrst_i)
        out_ff.hour_timer_power |-> !out_ff.hour_timer_reset;
    endproperty
    a_timer_power: assert property (p_timer_power) else $error("hour timer powered during reset"); // [RL10]

    property p_timeout_stops;
        @(posedge clk_i) disable iff (!nrst_i)
        (fail && tmo_ff) |=> (!run_ff ##1 !out_ff.pump1 && !out_ff.pump2);
    endproperty
    a_timeout_stops: assert property (p_timeout_stops) else $error("timeout did not stop pumps"); // [RL13]

    property p_fail_sel_hold;
        @(posedge clk_i) disable iff (!nrst_i)
        (fail && sp_prev_ff && sp_n) |=> $stable(sel_ff);
    endproperty
    a_fail_sel_hold: assert property (p_fail_sel_hold) else $error("selector toggled inside pulse"); // [RL16]
endmodule : rpa_alternator

`default_nettype wire

// ---- rpa_starter_model.sv ----
// motor starter model: auxiliary contacts follow the coils after a pickup delay
`timescale 1ns/100ps
`default_nettype none

//==============================================================================
// starter model
//==============================================================================
module rpa_starter_model #(
    parameter int unsigned DELAY = 3
) (
    input  wire logic              clk_i,
    input  wire logic              nrst_i,
    input  wire rpa_pkg::rpa_out_t coil_i,
    output logic                   aux1_o,
    output logic                   aux2_o
);
    import rpa_pkg::*;

    logic [DELAY-1:0] aux1_ff;
    logic [DELAY-1:0] aux2_ff;

    // contacts move on the falling edge, clear of the scan edge
    always_ff @(negedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            aux1_ff <= '0;
            aux2_ff <= '0;
        end else begin
            aux1_ff <= {aux1_ff[DELAY-2:0], coil_i.pump1};
            aux2_ff <= {aux2_ff[DELAY-2:0], coil_i.pump2};
        end
    end

    assign aux1_o = aux1_ff[DELAY-1];
    assign aux2_o = aux2_ff[DELAY-1];
endmodule : rpa_starter_model

`default_nettype wire

// ---- rpa_alternator_tb.sv ----
// self-checking testbench for the redundant pump alternator
`timescale 1ns/100ps
`default_nettype none

//==============================================================================
// testbench
//==============================================================================
module testbench;
    import rpa_pkg::*;

    // one clock per tick keeps the 30000-tick life count inside the run
    localparam int TICKS = 1;
    localparam int P1    = 3;
    localparam int P2    = 2;
    localparam int RS    = 0;

    logic         clk_i     = 1'b0;
    logic         nrst_i    = 1'b0;
    rpa_variant_t variant   = RPA_ALT_START;
    logic         stop_nc   = 1'b1;
    logic         start     = 1'b0;
    logic         low_press = 1'b0;
    logic         aux1;
    logic         aux2;
    rpa_in_t      in_s;
    rpa_out_t     out_s;
    int           err_count   = 0;
    int           comparisons = 0;

    always #20 clk_i = ~clk_i;

    assign in_s = {stop_nc, start, aux1, aux2, low_press};

    rpa_alternator #(.TICK_CYCLES(TICKS)) u_rpa_alternator (
        .clk_i     (clk_i),
        .nrst_i    (nrst_i),
        .variant_i (variant),
        .in_i      (in_s),
        .out_o     (out_s)
    );

    rpa_starter_model #(.DELAY(3)) u_rpa_starter_model (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .coil_i (out_s),
        .aux1_o (aux1),
        .aux2_o (aux2)
    );

//==============================================================================
// helpers
//==============================================================================
    task automatic check(input string name, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    endtask : check

    task automatic check_rng(input string name, input int lo, input int hi, input int got);
        comparisons++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("[ERR] %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask : check_rng

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask : cyc

    // bounded wait for one output bit; counts the cycles it took
    task automatic wait_out(input int b, input logic v, input int maxc, output int n);
        logic [3:0] ov;
        n = 0;
        ov = out_s;
        while (ov[b] !== v && n < maxc) begin
            @(negedge clk_i);
            n++;
            ov = out_s;
        end
        check($sformatf("output bit %0d", b), v, ov[b]);
    endtask : wait_out

    task automatic do_reset(input rpa_variant_t v);
        @(negedge clk_i);
        nrst_i = 1'b0;
        variant = v;
        stop_nc = 1'b1;
        start = 1'b0;
        low_press = 1'b0;
        cyc(20);
        nrst_i = 1'b1;
        cyc(2);
    endtask : do_reset

//==============================================================================
// scenarios
//==============================================================================
    task automatic test_alt();
        int         n;
        int         b;
        logic [3:0] ov;
        do_reset(RPA_ALT_START);
        for (int i = 0; i < 3; i++) begin
            b = (i % 2 == 0) ? P2 : P1;
            start = 1'b1;
            wait_out(b, 1'b1, 6, n);
            ov = out_s;
            check("alt other pump idle", 1'b0, ov[P1 + P2 - b]);
            cyc(4);
            start = 1'b0;
            cyc(6);
            ov = out_s;
            check("alt pump held by aux", 1'b1, ov[b]);
            if (i == 0) begin
                // start pressed again while running must not swap pumps
                start = 1'b1;
                cyc(3);
                start = 1'b0;
                cyc(3);
                check("alt busy start pump2", 1'b1, out_s.pump2);
                check("alt busy start pump1", 1'b0, out_s.pump1);
            end
            stop_nc = 1'b0;
            cyc(3);
            ov = out_s;
            check("alt stop drops pump", 1'b0, ov[b]);
            cyc(6);
            stop_nc = 1'b1;
            cyc(2);
        end
        $display("test alternate start done");
    endtask : test_alt

    task automatic test_timed();
        int n;
        do_reset(RPA_TIMED_SWITCH);
        start = 1'b1;
        wait_out(RS, 1'b1, 5, n);
        wait_out(RS, 1'b0, 30 * TICKS, n);
        check_rng("start pulse length", 19 * TICKS - 1, 21 * TICKS + 1, n);
        check("timed pump1 runs", 1'b1, out_s.pump1);
        check("timed pump2 idle", 1'b0, out_s.pump2);
        start = 1'b0;
        cyc(2);
        check("hour timer powered", 1'b1, out_s.hour_timer_power);
        wait_out(RS, 1'b1, 30100 * TICKS, n);
        check_rng("life time", 29950 * TICKS, 30010 * TICKS, n);
        cyc(1);
        check("hour timer off in reset", 1'b0, out_s.hour_timer_power);
        wait_out(P2, 1'b1, 6, n);
        wait_out(P1, 1'b0, 60 * TICKS, n);
        check_rng("pump1 off delay", 46 * TICKS, 55 * TICKS, n);
        cyc(25 * TICKS);
        stop_nc = 1'b0;
        cyc(45 * TICKS);
        check("pump2 in off delay", 1'b1, out_s.pump2);
        wait_out(P2, 1'b0, 12 * TICKS, n);
        stop_nc = 1'b1;
        $display("test timed switch done");
    endtask : test_timed

    task automatic test_fail();
        int n;
        do_reset(RPA_SWITCH_ON_FAIL);
        start = 1'b1;
        wait_out(P2, 1'b1, 6, n);
        check("fail pump1 idle", 1'b0, out_s.pump1);
        cyc(3);
        start = 1'b0;
        cyc(25 * TICKS);
        check("fail pump2 held", 1'b1, out_s.pump2);
        low_press = 1'b1;
        wait_out(P1, 1'b1, 6, n);
        check("fail pump2 dropped", 1'b0, out_s.pump2);
        wait_out(P1, 1'b0, 120 * TICKS, n);
        check_rng("low pressure timeout", 95 * TICKS, 103 * TICKS, n);
        check("fail pump2 after timeout", 1'b0, out_s.pump2);
        low_press = 1'b0;
        cyc(8);
        start = 1'b1;
        wait_out(P2, 1'b1, 6, n);
        cyc(3);
        start = 1'b0;
        stop_nc = 1'b0;
        wait_out(P2, 1'b0, 4, n);
        stop_nc = 1'b1;
        $display("test switch on failure done");
    endtask : test_fail

//==============================================================================
// run control
//==============================================================================
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test

    initial begin
        test_alt();
        test_timed();
        test_fail();
        finish_test();
    end

    // whole run is about 31000 cycles
    initial begin
        repeat (40000) @(posedge clk_i);
        err_count++;
        $display("watchdog expired");
        finish_test();
    end
endmodule : testbench

`default_nettype wire
